// ### design/dbrd_defines.vh
`ifndef DBRD_DEFINES_VH
`define DBRD_DEFINES_VH

// Register byte offsets.
`define DBRD_OFS_CTRL 8'h00
`define DBRD_OFS_RX_CODE 8'h04
`define DBRD_OFS_TX_CODE 8'h08
`define DBRD_OFS_STATUS 8'h0C
`define DBRD_OFS_RX_DIV 8'h10
`define DBRD_OFS_TX_DIV 8'h14

// Control register fields.
`define DBRD_CTRL_EXT_CLK 0
`define DBRD_CTRL_SINGLE 1
`define DBRD_CTRL_QREF_EN 2
`define DBRD_CTRL_RST 3'h4

// Status register fields.
`define DBRD_STAT_RX_OUT 0
`define DBRD_STAT_TX_OUT 1
`define DBRD_STAT_RX_SETTLING 2
`define DBRD_STAT_TX_SETTLING 3

// Reset value of both latched select codes.
`define DBRD_CODE_RST 4'h0

// Timing.
`define DBRD_CLK_PERIOD_NS 40
`define DBRD_STROBE_MIN_NS 150
`define DBRD_STROBE_MIN_CYC \
  ((`DBRD_STROBE_MIN_NS + `DBRD_CLK_PERIOD_NS - 1) / `DBRD_CLK_PERIOD_NS)
`define DBRD_SETTLE_PERIODS 5'h12

// Mask table: divisor for each select code.
`define DBRD_DIV_0 15'h1800
`define DBRD_DIV_1 15'h1000
`define DBRD_DIV_2 15'h0AE9
`define DBRD_DIV_3 15'h08EC
`define DBRD_DIV_4 15'h0800
`define DBRD_DIV_5 15'h0400
`define DBRD_DIV_6 15'h0200
`define DBRD_DIV_7 15'h0100
`define DBRD_DIV_8 15'h00AB
`define DBRD_DIV_9 15'h009A
`define DBRD_DIV_A 15'h0080
`define DBRD_DIV_B 15'h0055
`define DBRD_DIV_C 15'h0040
`define DBRD_DIV_D 15'h002B
`define DBRD_DIV_E 15'h0020
`define DBRD_DIV_F 15'h0010

`endif

// ### design/dbrd_top.v
// The Wishbone slave port and the address map are this design's own decisions.
`include "dbrd_defines.vh"
`default_nettype none

module dbrd_top
(
  input wire clk, // System clock, 25 MHz.
  input wire reset_n, // Asynchronous reset, active low.
  input wire wb_cyc_i, // Wishbone cycle.
  input wire wb_stb_i, // Wishbone strobe.
  input wire wb_we_i, // Wishbone write enable.
  input wire [7:0] wb_adr_i, // Wishbone byte address.
  input wire [31:0] wb_dat_i, // Wishbone write data.
  input wire [3:0] wb_sel_i, // Wishbone byte selects.
  output wire [31:0] wb_dat_o, // Wishbone read data.
  output wire wb_ack_o, // Wishbone acknowledge.
  input wire master_clock_in_a, // External master clock for cascading.
  input wire rx_select_bit0, // Receive select code bit 0.
  input wire rx_select_bit1, // Receive select code bit 1.
  input wire rx_select_bit2, // Receive select code bit 2.
  input wire rx_select_bit3, // Receive select code bit 3.
  input wire tx_select_bit0, // Transmit select code bit 0.
  input wire tx_select_bit1, // Transmit select code bit 1.
  input wire tx_select_bit2, // Transmit select code bit 2.
  input wire tx_select_bit3, // Transmit select code bit 3.
  input wire rx_select_load, // Receive code load, active high level.
  input wire tx_select_load, // Transmit code load, active high level.
  output wire rx_rate_out, // Receive bit clock.
  output wire tx_rate_out, // Transmit bit clock.
  output wire quarter_reference_out // Master clock divided by four.
);

  //////////////////////////////////////////////////////////////////////////////

  function [14:0] dbrd_divisor;
    input [3:0] code;
    begin
      case (code)
        4'h0: dbrd_divisor = `DBRD_DIV_0;
        4'h1: dbrd_divisor = `DBRD_DIV_1;
        4'h2: dbrd_divisor = `DBRD_DIV_2;
        4'h3: dbrd_divisor = `DBRD_DIV_3;
        4'h4: dbrd_divisor = `DBRD_DIV_4;
        4'h5: dbrd_divisor = `DBRD_DIV_5;
        4'h6: dbrd_divisor = `DBRD_DIV_6;
        4'h7: dbrd_divisor = `DBRD_DIV_7;
        4'h8: dbrd_divisor = `DBRD_DIV_8;
        4'h9: dbrd_divisor = `DBRD_DIV_9;
        4'hA: dbrd_divisor = `DBRD_DIV_A;
        4'hB: dbrd_divisor = `DBRD_DIV_B;
        4'hC: dbrd_divisor = `DBRD_DIV_C;
        4'hD: dbrd_divisor = `DBRD_DIV_D;
        4'hE: dbrd_divisor = `DBRD_DIV_E;
        default: dbrd_divisor = `DBRD_DIV_F;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  wire [10:0] pins_raw;
  reg [10:0] pins_s1_r;
  reg [10:0] pins_s2_r;
  reg mclk_s3_r;

  assign pins_raw = {master_clock_in_a, tx_select_load, rx_select_load,
                     tx_select_bit3, tx_select_bit2, tx_select_bit1,
                     tx_select_bit0, rx_select_bit3, rx_select_bit2,
                     rx_select_bit1, rx_select_bit0};

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pins_s1_r <= 11'h000;
      pins_s2_r <= 11'h000;
      mclk_s3_r <= 1'b0;
    end
    else
    begin
      pins_s1_r <= pins_raw;
      pins_s2_r <= pins_s1_r;
      mclk_s3_r <= pins_s2_r[10];
    end
  end

  wire [7:0] sel_s2;
  wire [1:0] load_s2;

  assign sel_s2 = pins_s2_r[7:0];
  assign load_s2 = pins_s2_r[9:8];

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone slave.

  reg [2:0] ctrl_r;
  reg ack_r;
  reg [31:0] dat_r;
  wire req;
  wire wr_take;
  wire [1:0] sw_load;
  wire [7:0] code_vec;
  wire [1:0] rate_vec;
  wire [1:0] settle_vec;
  wire ext_clk;
  wire single_mode;
  wire tick;

  assign req = wb_cyc_i & wb_stb_i;
  // A write lands at the edge where the master sees ack.
  assign wr_take = req & wb_we_i & ack_r & wb_sel_i[0];
  assign sw_load[0] = wr_take & (wb_adr_i == `DBRD_OFS_RX_CODE);
  assign sw_load[1] = wr_take & (wb_adr_i == `DBRD_OFS_TX_CODE);
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign ext_clk = ctrl_r[`DBRD_CTRL_EXT_CLK];
  assign single_mode = ctrl_r[`DBRD_CTRL_SINGLE];

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
      ctrl_r <= `DBRD_CTRL_RST;
    end
    else
    begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r & ~wb_we_i)
      begin
        case (wb_adr_i)
          `DBRD_OFS_CTRL: dat_r <= {29'h0, ctrl_r};
          `DBRD_OFS_RX_CODE: dat_r <= {28'h0, code_vec[3:0]};
          `DBRD_OFS_TX_CODE: dat_r <= {28'h0, code_vec[7:4]};
          `DBRD_OFS_STATUS: dat_r <= {28'h0, settle_vec, rate_vec};
          `DBRD_OFS_RX_DIV: dat_r <= {17'h0, dbrd_divisor(code_vec[3:0])};
          `DBRD_OFS_TX_DIV: dat_r <= {17'h0, dbrd_divisor(code_vec[7:4])};
          default: dat_r <= 32'h00000000;
        endcase
      end
      else
      begin
        dat_r <= 32'h00000000;
      end
      if (wr_take & (wb_adr_i == `DBRD_OFS_CTRL))
      begin
        ctrl_r <= wb_dat_i[2:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Master tick: every clk edge, or each rising edge of the external
  // master clock so that one divider can be cascaded behind another.

  assign tick = ext_clk ? (pins_s2_r[10] & ~mclk_s3_r) : 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // Divider channels: 0 is receive, 1 is transmit.

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_chan
      reg [3:0] code_r;
      reg [3:0] prev_r;
      reg [14:0] cnt_r;
      reg out_r;
      reg [4:0] settle_r;
      wire [14:0] div;
      wire [14:0] hi_len;
      wire [14:0] cnt_nxt;
      wire restart;
      wire run;

      assign div = dbrd_divisor(code_r);
      // High phase is the larger half, so odd divisors differ by one tick.
      assign hi_len = div - {1'b0, div[14:1]};
      assign cnt_nxt = (cnt_r == div - 15'h0001) ? 15'h0000 :
                       cnt_r + 15'h0001;
      assign restart = (code_r != prev_r);
      // The transmit channel sleeps in single-channel mode.
      assign run = ~((ch == 1) & single_mode);

      always @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          code_r <= `DBRD_CODE_RST;
          prev_r <= `DBRD_CODE_RST;
          cnt_r <= 15'h0000;
          out_r <= 1'b0;
          settle_r <= 5'h00;
        end
        else
        begin
          // A held-high load pin follows the pins and beats a bus write.
          if (load_s2[ch])
          begin
            code_r <= sel_s2[ch*4 +: 4];
          end
          else if (sw_load[ch])
          begin
            code_r <= wb_dat_i[3:0];
          end
          prev_r <= code_r;
          if (!run)
          begin
            cnt_r <= 15'h0000;
            out_r <= 1'b0;
            settle_r <= 5'h00;
          end
          else if (restart)
          begin
            // Start a fresh high phase; the old one is abandoned whole.
            cnt_r <= 15'h0000;
            out_r <= 1'b1;
            settle_r <= 5'h00;
          end
          else if (tick)
          begin
            cnt_r <= cnt_nxt;
            out_r <= (cnt_nxt < hi_len);
            if (settle_r != `DBRD_SETTLE_PERIODS)
            begin
              settle_r <= settle_r + 5'h01;
            end
          end
        end
      end

      assign code_vec[ch*4 +: 4] = code_r;
      assign rate_vec[ch] = out_r;
      assign settle_vec[ch] = run & (settle_r != `DBRD_SETTLE_PERIODS);
    end
  endgenerate

  assign rx_rate_out = rate_vec[0];
  assign tx_rate_out = rate_vec[1];

  //////////////////////////////////////////////////////////////////////////////
  // Quarter-frequency reference, independent of both codes.

  reg [1:0] qref_r;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      qref_r <= 2'h0;
    end
    else if (!ctrl_r[`DBRD_CTRL_QREF_EN])
    begin
      qref_r <= 2'h0;
    end
    else if (tick)
    begin
      qref_r <= qref_r + 2'h1;
    end
  end

  assign quarter_reference_out = qref_r[1];

endmodule

`default_nettype wire

// ### sim/dbrd_checker.sv
`default_nettype none
module dbrd_checker (
  input wire logic clk, // Clock.
  input wire logic reset_n, // Reset.
  input wire logic wb_cyc_i, // Cycle.
  input wire logic wb_stb_i, // Strobe.
  input wire logic [7:0] wb_adr_i, // Address.
  input wire logic [31:0] wb_dat_o, // Read data.
  input wire logic wb_ack_o, // Ack.
  input wire logic rx_rate_out, // Rate.
  input wire logic quarter_reference_out // Reference.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_high8;
    rx_rate_out [*8];
  endsequence
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_unmapped_zero: assert property (
    wb_ack_o && wb_adr_i > 8'h14 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // The shortest divisor is 16, so no high phase may be under 8 clocks.
  a_rx_high_min: assert property ($rose(rx_rate_out) |-> s_high8)
    else $error("receive high phase too short");
  a_qref_steady: assert property (
    $changed(quarter_reference_out) |=> $stable(quarter_reference_out))
    else $error("reference phase too short");
  a_outs_start: assert property ($rose(reset_n) |-> ##[1:2] rx_rate_out)
    else $error("receive output did not start");
endmodule
bind dbrd_top dbrd_checker i_dbrd_checker (.clk, .reset_n, .wb_cyc_i,
  .wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .rx_rate_out,
  .quarter_reference_out);
`default_nettype wire

// ### sim/dbrd_bitclk_sink.sv
`default_nettype none
module dbrd_bitclk_sink (
  input wire logic clk, // Sampling clock.
  input wire logic rate, // Bit clock in.
  output int per, // Last period.
  output int hi // Last high phase.
);
  timeunit 1ns;
  timeprecision 1ns;
  int c = 0;
  int h = 0;
  logic q = 1'h0;
  // A receiver times whole periods from rise to rise, so a cut phase shows.
  always @(posedge clk)
  begin
    q <= rate;
    if (rate && !q)
    begin
      per <= c;
      hi <= h;
      c <= 1;
      h <= 1;
    end
    else
    begin
      c <= c + 1;
      h <= h + int'(rate);
    end
  end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [3:0] rxp = 4'h0;
  logic [3:0] txp = 4'h0;
  logic rx_select_load = 1'h0;
  logic tx_select_load = 1'h0;
  logic master_clock_in_a = 1'h0;
  logic [1:0] ec = 2'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, rx_rate_out, tx_rate_out, quarter_reference_out, acc;
  int n_mismatch = 0;
  int checked = 0;
  int per_r, hi_r, per_t, hi_t, per_q, hi_q;
  logic [14:0] tbl [16] = '{15'h1800, 15'h1000, 15'h0AE9, 15'h08EC,
    15'h0800, 15'h0400, 15'h0200, 15'h0100, 15'h00AB, 15'h009A,
    15'h0080, 15'h0055, 15'h0040, 15'h002B, 15'h0020, 15'h0010};
  always #20 clk = ~clk;
  // Cascade source: one rising edge every 8 clocks.
  always @(posedge clk)
  begin
    ec <= ec + 2'h1;
    if (ec == 2'h3)
      master_clock_in_a <= ~master_clock_in_a;
  end
  dbrd_top i_dbrd_top (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
    .master_clock_in_a, .rx_select_bit0(rxp[0]), .rx_select_bit1(rxp[1]),
    .rx_select_bit2(rxp[2]), .rx_select_bit3(rxp[3]),
    .tx_select_bit0(txp[0]), .tx_select_bit1(txp[1]),
    .tx_select_bit2(txp[2]), .tx_select_bit3(txp[3]), .rx_select_load,
    .tx_select_load, .rx_rate_out, .tx_rate_out, .quarter_reference_out);
  dbrd_bitclk_sink i_rx_sink (.clk, .rate(rx_rate_out), .per(per_r),
    .hi(hi_r));
  dbrd_bitclk_sink i_tx_sink (.clk, .rate(tx_rate_out), .per(per_t),
    .hi(hi_t));
  dbrd_bitclk_sink i_q_sink (.clk, .rate(quarter_reference_out),
    .per(per_q), .hi(hi_q));
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'h1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (wb_ack_o !== 1'h1)
    begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic t_regs;
    rdchk("ctrl", 8'h00, 32'h4);
    rdchk("rx_code", 8'h04, 32'h0);
    rdchk("rx_div", 8'h10, 32'h1800);
    rdchk("unmapped", 8'h20, 32'h0);
  endtask
  task automatic t_table;
    for (int c = 0; c < 16; c++)
    begin
      bus(1'h1, 8'h04, 32'(c));
      bus(1'h1, 8'h08, 32'(15 - c));
      rdchk("rx_div", 8'h10, 32'(tbl[c]));
      rdchk("tx_div", 8'h14, 32'(tbl[15 - c]));
    end
  endtask
  task automatic t_rates;
    bus(1'h1, 8'h04, 32'hF);
    bus(1'h1, 8'h08, 32'hD);
    wt(150);
    chk("rx_per", 32'(per_r), 32'h10);
    chk("rx_hi", 32'(hi_r), 32'h8);
    chk("tx_per", 32'(per_t), 32'h2B);
    chk("tx_hi", 32'(hi_t), 32'h16);
    chk("q_per", 32'(per_q), 32'h4);
  endtask
  task automatic t_pins;
    rxp <= 4'hC;
    txp <= 4'hB;
    wt(1);
    rx_select_load <= 1'h1;
    tx_select_load <= 1'h1;
    wt(4);
    rx_select_load <= 1'h0;
    tx_select_load <= 1'h0;
    wt(2);
    rxp <= 4'h0;
    txp <= 4'h0;
    wt(300);
    chk("rx_per", 32'(per_r), 32'h40);
    chk("tx_per", 32'(per_t), 32'h55);
    chk("tx_hi", 32'(hi_t), 32'h2B);
  endtask
  task automatic t_follow;
    tx_select_load <= 1'h1;
    txp <= 4'hE;
    wt(6);
    rdchk("tx_code", 8'h08, 32'hE);
    txp <= 4'hA;
    wt(6);
    bus(1'h1, 8'h08, 32'h3);
    rdchk("tx_code", 8'h08, 32'hA);
    tx_select_load <= 1'h0;
  endtask
  task automatic t_single;
    bus(1'h1, 8'h00, 32'h6);
    wt(3);
    acc = 1'h0;
    // Sample away from the launching edge so the value is settled.
    repeat (100) @(negedge clk) acc |= tx_rate_out;
    chk("tx_off", 32'(acc), 32'h0);
    chk("rx_per", 32'(per_r), 32'h40);
    bus(1'h1, 8'h00, 32'h4);
  endtask
  task automatic t_cascade;
    bus(1'h1, 8'h00, 32'h5);
    bus(1'h1, 8'h04, 32'hF);
    wt(700);
    chk("rx_per", 32'(per_r), 32'h80);
    chk("q_per", 32'(per_q), 32'h20);
    bus(1'h1, 8'h00, 32'h4);
  endtask
  task automatic t_status;
    bus(1'h1, 8'h04, 32'hE);
    bus(1'h0, 8'h0C, 32'h0);
    chk("settling", 32'(rd[3:2]), 32'h1);
    wt(30);
    bus(1'h0, 8'h0C, 32'h0);
    chk("settled", 32'(rd[3:2]), 32'h0);
    wt(100);
    chk("rx_per", 32'(per_r), 32'h20);
  endtask
  initial
  begin
    wt(6);
    reset_n <= 1'h1;
    t_regs();
    t_table();
    t_rates();
    t_pins();
    t_follow();
    t_single();
    t_cascade();
    t_status();
    summarize();
  end
endmodule
`default_nettype wire
